// ==== dv/uct_peer.sv ====
// Remote serial peer: decodes frames from the unit, sends frames to it.
// Assumes kdiv matches the unit's divisor and send is called at a clock edge.
`default_nettype none
module uct_peer (
  input wire logic core_clk,
  input wire logic txd,
  input wire logic [7:0] kdiv,
  output var logic rxd,
  output var logic stb,
  output var logic [7:0] got,
  output var logic ok,
  output var logic [15:0] gap
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] f;
  longint t_last;
  initial begin
    rxd = 1'b1;
    stb = 1'b0;
    got = 8'h00;
    ok = 1'b0;
    gap = 16'h0000;
    t_last = 0;
  end
  // Time taken from the start edge, not a cycle count, to dodge edge races
  initial forever begin
    @(negedge txd);
    gap <= 16'(($time - t_last) / 100);
    t_last = $time;
    repeat (kdiv) @(posedge core_clk);
    for (int i = 0; i < 11; i++) begin
      f[i] = txd;
      if (i < 10) repeat (2 * kdiv) @(posedge core_clk);
    end
    got <= f[8:1];
    ok <= !f[0] && f[10] && (f[9] == ^f[8:1]);
    stb <= 1'b1;
    @(posedge core_clk);
    stb <= 1'b0;
  end
  // Even parity; bad_par and bad_stop break a frame on purpose
  task automatic send(input logic [7:0] d, input logic bad_par,
                      input logic bad_stop, input int tail);
    logic [10:0] fr;
    fr = {~bad_stop, (^d) ^ bad_par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= fr[i];
      repeat (2 * kdiv) @(posedge core_clk);
    end
    rxd <= 1'b1;
    repeat (tail) @(posedge core_clk);
  endtask : send
endmodule : uct_peer
`default_nettype wire

// ==== dv/uct_uart_tb.sv ====
// Testbench of the serial unit: register bus master, serial peer, checks.
// Assumes the register map and bus timing of the unit's hand-over.
`default_nettype none
module uct_uart_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] K = 8'h04;
  logic core_clk, rst_n, unit_clk_en, quiet;
  logic [7:0] awaddr, araddr, p_got;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic arvalid, arready, rvalid, rready, rxd, txd, irq, p_stb, p_ok;
  logic [15:0] p_gap;
  int mismatches, tests_run;
  logic [33:0] rd_q[$];
  logic [23:0] tx_q[$];
  logic [1:0] wr_q[$];
  uct_uart u_uct_uart (.core_clk(core_clk), .rst_n(rst_n),
    .unit_clk_en(unit_clk_en), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serial_receive_input(rxd), .serial_transmit_output(txd), .irq(irq));
  uct_peer u_uct_peer (.core_clk(core_clk), .txd(txd), .kdiv(K),
    .rxd(rxd), .stb(p_stb), .got(p_got), .ok(p_ok), .gap(p_gap));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic check(input string nm, input logic [33:0] seen,
                       input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic tmo();
    mismatches++;
    print_verdict();
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    // Only the aligned offsets of the map answer OKAY
    wr_q.push_back((a > uct_pkg::OFF_STAT || a[1:0] != 2'h0) ?
                   uct_pkg::RESP_ERR : uct_pkg::RESP_OK);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    // Ready stays up so back-to-back calls never drive it twice in a step
    end while (bvalid !== 1'b1 && n < 200);
    if (n >= 200) tmo();
  endtask : wr
  // The read's expectation is noted here and judged by the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    n = 0;
    rd_q.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    if (n >= 200) tmo();
  endtask : rd
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask : wait_cyc
  always @(posedge core_clk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && rd_q.size() > 0) begin
      check("read", {rresp, rdata}, rd_q.pop_front());
    end
    if (bvalid === 1'b1 && bready === 1'b1 && wr_q.size() > 0) begin
      check("write resp", bresp, wr_q.pop_front());
    end
    if (p_stb === 1'b1 && quiet === 1'b0) begin
      if (tx_q.size() == 0) begin
        check("extra frame", 34'h1, 34'h0);
      end else begin
        check("frame byte", p_got, tx_q[0][7:0]);
        check("frame shape", p_ok, 1'b1);
        if (tx_q[0][23:8] != 0) check("gap", p_gap, tx_q[0][23:8]);
        void'(tx_q.pop_front());
      end
    end
  end
  initial begin
    logic [7:0] a, b, c, v;
    int n;
    rst_n = 1'b0;
    unit_clk_en = 1'b1;
    quiet = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    mismatches = 0;
    tests_run = 0;
    void'($urandom(28));
    wait_cyc(12);
    rst_n <= 1'b1;
    wait_cyc(2);
    rd(uct_pkg::OFF_CTRL, 32'h0, uct_pkg::RESP_OK);
    rd(uct_pkg::OFF_DIV, 32'hFF, uct_pkg::RESP_OK);
    rd(8'h20, 32'h0, uct_pkg::RESP_ERR);
    wr(8'h20, 32'h5);
    wr(uct_pkg::OFF_CTRL, 32'h1);
    wr(uct_pkg::OFF_CTRL, 32'h7);
    wr(uct_pkg::OFF_DIV, 32'h3);
    rd(uct_pkg::OFF_DIV, 32'hFF, uct_pkg::RESP_OK);
    wr(uct_pkg::OFF_DIV, {24'h0, K});
    rd(uct_pkg::OFF_DIV, {24'h0, K}, uct_pkg::RESP_OK);
    wr(uct_pkg::OFF_IMSK, 32'h1);
    $display("test setup done");
    // Second and third bytes are queued while a frame runs: continuous
    a = 8'($urandom());
    b = 8'($urandom());
    tx_q.push_back({16'h0, a});
    wr(uct_pkg::OFF_TXD, {24'h0, a});
    tx_q.push_back({16'(K * 22 + 2), b});
    wr(uct_pkg::OFF_TXD, {24'h0, b});
    wait_cyc(100);
    tx_q.push_back({16'(K * 22 + 2), b});
    wr(uct_pkg::OFF_TXD, {24'h0, b});
    n = 0;
    while (tx_q.size() > 0 && n < 3000) begin
      wait_cyc(1);
      n++;
    end
    if (n >= 3000) tmo();
    wait_cyc(20);
    check("idle line", txd, 1'b1);
    check("irq on", irq, 1'b1);
    wr(uct_pkg::OFF_IMSK, 32'h0);
    wait_cyc(2);
    check("irq masked", irq, 1'b0);
    rd(uct_pkg::OFF_IST, 32'h1, uct_pkg::RESP_OK);
    wr(uct_pkg::OFF_IST, 32'h3);
    rd(uct_pkg::OFF_IST, 32'h0, uct_pkg::RESP_OK);
    $display("test transmit done");
    // Two frames with a short gap; the second overruns the first
    a = 8'($urandom());
    c = 8'($urandom());
    wr(uct_pkg::OFF_IMSK, 32'h1);
    u_uct_peer.send(a, 1'b0, 1'b0, 2);
    u_uct_peer.send(c, 1'b0, 1'b0, 20);
    rd(uct_pkg::OFF_RXD, {24'h0, c}, uct_pkg::RESP_OK);
    rd(uct_pkg::OFF_ERR, 32'h2, uct_pkg::RESP_OK);
    check("irq err", irq, 1'b0);
    wr(uct_pkg::OFF_ERR, 32'h7);
    rd(uct_pkg::OFF_ERR, 32'h0, uct_pkg::RESP_OK);
    u_uct_peer.send(a, 1'b1, 1'b1, 20);
    rd(uct_pkg::OFF_ERR, 32'h5, uct_pkg::RESP_OK);
    rd(uct_pkg::OFF_RXD, {24'h0, a}, uct_pkg::RESP_OK);
    check("irq err", irq, 1'b0);
    // Odd parity selected: a frame with an odd count of ones is clean
    wr(uct_pkg::OFF_ERR, 32'h7);
    wr(uct_pkg::OFF_CTRL, 32'hF);
    u_uct_peer.send(c, 1'b1, 1'b0, 20);
    rd(uct_pkg::OFF_ERR, 32'h0, uct_pkg::RESP_OK);
    rd(uct_pkg::OFF_RXD, {24'h0, c}, uct_pkg::RESP_OK);
    $display("test receive done");
    // Halt the unit clock in the middle of a frame
    quiet = 1'b1;
    wr(uct_pkg::OFF_TXD, 32'h0);
    n = 0;
    while (txd !== 1'b0 && n < 100) begin
      wait_cyc(1);
      n++;
    end
    if (n >= 100) tmo();
    wait_cyc(3);
    v = {7'h0, txd};
    unit_clk_en <= 1'b0;
    n = 0;
    repeat (40) begin
      wait_cyc(1);
      if (txd !== v[0]) n++;
    end
    check("held pin", n, 0);
    check("held level", v, 8'h0);
    unit_clk_en <= 1'b1;
    rd(uct_pkg::OFF_DIV, {24'h0, K}, uct_pkg::RESP_OK);
    rd(uct_pkg::OFF_STAT, 32'h1, uct_pkg::RESP_OK);
    wr(uct_pkg::OFF_CTRL, 32'h0);
    wait_cyc(2);
    check("reinit line", txd, 1'b1);
    wait_cyc(150);
    quiet = 1'b0;
    $display("test halt done");
    wr(uct_pkg::OFF_CTRL, 32'h7);
    wr(uct_pkg::OFF_CTRL, 32'h1);
    wr(uct_pkg::OFF_CTRL, 32'h0);
    rd(uct_pkg::OFF_CTRL, 32'h0, uct_pkg::RESP_OK);
    check("stopped line", txd, 1'b1);
    wait_cyc(5);
    $display("test stop done");
    print_verdict();
  end
endmodule : uct_uart_tb
`default_nettype wire

// ==== logic/uct_bit_timer.sv ====
// Bit timer: one bit length is 2*k base clocks.
// Assumes run and restart come from logic on core_clk.
`default_nettype none
module uct_bit_timer (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic restart,
  input wire logic [7:0] kdiv,
  output logic mid,
  output logic done
);
  typedef struct packed {
    logic [8:0] cnt;
  } uct_tmr_t;
  uct_tmr_t q, d;
  logic [8:0] last;

  always_comb begin
    last = {kdiv, 1'b0} - 9'h001;
    d = q;
    if (restart) begin
      d.cnt = 9'h000;
    end else if (run) begin
      d.cnt = (q.cnt == last) ? 9'h000 : q.cnt + 9'h001;
    end
    // Done never looks at restart, so no loop through the caller
    done = run && (q.cnt == last);
    mid = run && (q.cnt == ({1'b0, kdiv} - 9'h001));
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : uct_bit_timer
`default_nettype wire

// ==== logic/uct_pkg.sv ====
// Constants shared by the serial unit and its testbench.
// Assumes one core clock; the base clock of the baud divider is core_clk.
`default_nettype none
package uct_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DIV = 8'h04;
  localparam logic [7:0] OFF_TXD = 8'h08;
  localparam logic [7:0] OFF_RXD = 8'h0C;
  localparam logic [7:0] OFF_ERR = 8'h10;
  localparam logic [7:0] OFF_IST = 8'h14;
  localparam logic [7:0] OFF_IMSK = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  // Control field positions
  localparam int CTRL_PWR = 0;
  localparam int CTRL_TXE = 1;
  localparam int CTRL_RXE = 2;
  localparam int CTRL_ODD = 3;
  // Error and interrupt field positions
  localparam int ERR_PAR = 0;
  localparam int ERR_OVR = 1;
  localparam int ERR_FRM = 2;
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  // Reset values and limits
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [7:0] DIV_RST = 8'hFF;
  localparam logic [7:0] DIV_MIN = 8'h04;
  // Frame: start, 8 data, parity, stop
  localparam logic [3:0] FRAME_LAST = 4'hA;
  localparam logic [1:0] GAP_LAST = 2'h1;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_GAP} uct_tx_st_t;
  typedef enum logic {RX_IDLE, RX_BITS} uct_rx_st_t;
endpackage : uct_pkg
`default_nettype wire

// ==== logic/uct_uart.sv ====
// Asynchronous serial unit with an AXI4-Lite register slave.
// Assumes unit_clk_en comes from the clock controller on core_clk and
// serial_receive_input comes from a pin.
`default_nettype none
module uct_uart (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic unit_clk_en,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic serial_receive_input,
  output logic serial_transmit_output,
  output logic irq
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_ok;
    logic [7:0] awa;
    logic w_ok;
    logic [7:0] wd;
    logic wen;
    logic [3:0] ctrl;
    logic [7:0] kdiv;
    logic [7:0] txdata;
    logic pend;
    logic [7:0] rxdata;
    logic rxv;
    logic [2:0] err;
    logic [1:0] ist;
    logic [1:0] imask;
    logic irq;
    uct_pkg::uct_tx_st_t tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_idx;
    logic [1:0] gap;
    logic txo;
    uct_pkg::uct_rx_st_t rx_st;
    logic [3:0] rx_idx;
    logic [9:0] rx_sh;
    logic rx1;
    logic rx2;
    logic rx3;
  } uct_state_t;

  uct_state_t q, d;
  logic en, tx_ld, rx_go, t_done, r_mid, pwr, wr_go, rd_go;
  logic [9:0] nsh;

  assign en = unit_clk_en;
  uct_bit_timer u_tx_tmr (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(en && q.tx_st == uct_pkg::TX_SHIFT),
    .restart(tx_ld),
    .kdiv(q.kdiv),
    .mid(),
    .done(t_done)
  );

  uct_bit_timer u_rx_tmr (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(en && q.rx_st == uct_pkg::RX_BITS),
    .restart(rx_go),
    .kdiv(q.kdiv),
    .mid(r_mid),
    .done()
  );

  always_comb begin
    d = q;
    tx_ld = 1'b0;
    rx_go = 1'b0;
    wr_go = 1'b0;
    rd_go = 1'b0;
    nsh = {q.rx2, q.rx_sh[9:1]};
    pwr = q.ctrl[uct_pkg::CTRL_PWR];
    // Nothing moves while the unit clock is halted, the pin included
    if (en) begin
      d.rx1 = serial_receive_input;
      d.rx2 = q.rx1;
      d.rx3 = q.rx2;
      // Write address and data are taken in either order
      if (awvalid && q.awready) begin
        d.aw_ok = 1'b1;
        d.awa = awaddr;
      end
      if (wvalid && q.wready) begin
        d.w_ok = 1'b1;
        d.wd = wdata[7:0];
        d.wen = wstrb[0];
      end
      if (q.bvalid && bready) begin
        d.bvalid = 1'b0;
      end
      if (q.aw_ok && q.w_ok && !q.bvalid) begin
        wr_go = 1'b1;
        d.aw_ok = 1'b0;
        d.w_ok = 1'b0;
        d.bvalid = 1'b1;
        d.bresp = uct_pkg::RESP_OK;
        case (q.awa)
          uct_pkg::OFF_CTRL: if (q.wen) d.ctrl = q.wd[3:0];
          uct_pkg::OFF_DIV: begin
            // Divisors below the minimum are refused, old value kept
            if (q.wen && q.wd >= uct_pkg::DIV_MIN) d.kdiv = q.wd;
          end
          uct_pkg::OFF_TXD: begin
            if (q.wen && pwr && q.ctrl[uct_pkg::CTRL_TXE]) begin
              d.txdata = q.wd;
              d.pend = 1'b1;
            end
          end
          uct_pkg::OFF_ERR: if (q.wen) d.err = q.err & ~q.wd[2:0];
          uct_pkg::OFF_IST: if (q.wen) d.ist = q.ist & ~q.wd[1:0];
          uct_pkg::OFF_IMSK: if (q.wen) d.imask = q.wd[1:0];
          uct_pkg::OFF_RXD, uct_pkg::OFF_STAT: ;
          default: d.bresp = uct_pkg::RESP_ERR;
        endcase
      end
      if (q.rvalid && rready) begin
        d.rvalid = 1'b0;
      end
      if (arvalid && q.arready) begin
        d.rvalid = 1'b1;
        d.rresp = uct_pkg::RESP_OK;
        d.rdata = 32'h0000_0000;
        case (araddr)
          uct_pkg::OFF_CTRL: d.rdata[3:0] = q.ctrl;
          uct_pkg::OFF_DIV: d.rdata[7:0] = q.kdiv;
          uct_pkg::OFF_TXD: d.rdata[7:0] = q.txdata;
          uct_pkg::OFF_RXD: begin
            d.rdata[7:0] = q.rxdata;
            d.rxv = 1'b0;
            rd_go = 1'b1;
          end
          uct_pkg::OFF_ERR: d.rdata[2:0] = q.err;
          uct_pkg::OFF_IST: d.rdata[1:0] = q.ist;
          uct_pkg::OFF_IMSK: d.rdata[1:0] = q.imask;
          uct_pkg::OFF_STAT: begin
            d.rdata[3:0] = {q.rxv, q.pend, q.rx_st == uct_pkg::RX_BITS,
                            q.tx_st != uct_pkg::TX_IDLE};
          end
          default: d.rresp = uct_pkg::RESP_ERR;
        endcase
      end

      // Transmitter
      if (!d.ctrl[uct_pkg::CTRL_PWR] || !d.ctrl[uct_pkg::CTRL_TXE]) begin
        d.tx_st = uct_pkg::TX_IDLE;
        d.pend = 1'b0;
        d.txo = 1'b1;
      end else begin
        case (q.tx_st)
          uct_pkg::TX_IDLE: begin
            d.txo = 1'b1;
            tx_ld = d.pend;
          end
          uct_pkg::TX_SHIFT: begin
            if (t_done) begin
              d.tx_sh = {1'b1, q.tx_sh[10:1]};
              d.tx_idx = q.tx_idx + 4'h1;
              d.txo = d.tx_sh[0];
              if (q.tx_idx == uct_pkg::FRAME_LAST) begin
                d.txo = 1'b1;
                d.ist[uct_pkg::IRQ_TX] = 1'b1;
                d.gap = 2'h0;
                // Next frame already waiting: insert the extra gap
                d.tx_st = d.pend ? uct_pkg::TX_GAP
                                 : uct_pkg::TX_IDLE;
              end
            end
          end
          uct_pkg::TX_GAP: begin
            d.gap = q.gap + 2'h1;
            tx_ld = (q.gap == uct_pkg::GAP_LAST);
          end
          default: d.tx_st = uct_pkg::TX_IDLE;
        endcase
        if (tx_ld) begin
          d.tx_st = uct_pkg::TX_SHIFT;
          d.pend = 1'b0;
          d.tx_idx = 4'h0;
          d.tx_sh = {1'b1, ^d.txdata ^ d.ctrl[uct_pkg::CTRL_ODD],
                     d.txdata, 1'b0};
          d.txo = 1'b0;
        end
      end

      // Receiver
      if (!d.ctrl[uct_pkg::CTRL_PWR] || !d.ctrl[uct_pkg::CTRL_RXE]) begin
        d.rx_st = uct_pkg::RX_IDLE;
      end else begin
        case (q.rx_st)
          uct_pkg::RX_IDLE: begin
            // Falling edge restarts the divisor counter from zero
            if (q.rx3 && !q.rx2) begin
              rx_go = 1'b1;
              d.rx_st = uct_pkg::RX_BITS;
              d.rx_idx = 4'h0;
            end
          end
          uct_pkg::RX_BITS: begin
            if (r_mid) begin
              d.rx_idx = q.rx_idx + 4'h1;
              if (q.rx_idx == 4'h0) begin
                // Glitch shorter than half a bit is not a start
                if (q.rx2) d.rx_st = uct_pkg::RX_IDLE;
              end else begin
                d.rx_sh = nsh;
              end
              // Back to idle at the stop sample so the next start is seen
              if (q.rx_idx == uct_pkg::FRAME_LAST) begin
                d.rx_st = uct_pkg::RX_IDLE;
                d.rxdata = nsh[7:0];
                d.rxv = 1'b1;
                d.ist[uct_pkg::IRQ_RX] = 1'b1;
                if (q.rxv && !rd_go) d.err[uct_pkg::ERR_OVR] = 1'b1;
                if (^nsh[8:0] ^ q.ctrl[uct_pkg::CTRL_ODD])
                  d.err[uct_pkg::ERR_PAR] = 1'b1;
                if (!nsh[9]) d.err[uct_pkg::ERR_FRM] = 1'b1;
              end
            end
          end
          default: d.rx_st = uct_pkg::RX_IDLE;
        endcase
      end
      // Power off clears the receive valid and error flags; rxdata and ist keep their values
      if (!d.ctrl[uct_pkg::CTRL_PWR]) begin
        d.err = 3'h0;
        d.rxv = 1'b0;
      end
      d.awready = !d.aw_ok && !d.bvalid;
      d.wready = !d.w_ok && !d.bvalid;
      d.arready = !d.rvalid;
      // Errors have no path here, only done events
      d.irq = |(d.ist & d.imask);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.ctrl <= uct_pkg::CTRL_RST;
      q.kdiv <= uct_pkg::DIV_RST;
      q.txo <= 1'b1;
      q.rx1 <= 1'b1;
      q.rx2 <= 1'b1;
      q.rx3 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rresp = q.rresp;
  assign rdata = q.rdata;
  assign serial_transmit_output = q.txo;
  assign irq = q.irq;

  // Checking helpers: cycles since the last frame load
  logic [15:0] fl_cnt, fl_want;
  assign fl_want = 16'(q.kdiv) * 16'h0016 + 16'h0001;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fl_cnt <= 16'h0000;
    end else if (tx_ld) begin
      fl_cnt <= 16'h0000;
    end else if (en) begin
      fl_cnt <= fl_cnt + 16'h0001;
    end
  end

  a_gap_two: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ($rose(q.tx_st == uct_pkg::TX_GAP) && en) ##1 en
    |-> q.tx_st == uct_pkg::TX_GAP ##1 q.tx_st == uct_pkg::TX_SHIFT)
    else $error("gap before next start is not two clocks");
  a_frame_len: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    tx_ld && q.tx_st == uct_pkg::TX_GAP |-> fl_cnt == fl_want)
    else $error("continuous frame length is not 22k plus 2");
  a_rx_resync: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    en && q.rx_st == uct_pkg::RX_IDLE && q.rx3 && !q.rx2
    && d.ctrl[uct_pkg::CTRL_PWR] && d.ctrl[uct_pkg::CTRL_RXE]
    |=> q.rx_st == uct_pkg::RX_BITS && q.rx_idx == 4'h0 && !r_mid)
    else $error("start bit did not restart receive timing");

  a_halt_freeze: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !en |=> q == $past(q))
    else $error("state changed while unit clock halted");
  a_pin_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !en ##1 !en |-> $stable(serial_transmit_output))
    else $error("transmit pin moved while clock halted");

  a_err_no_irq: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (q.ist & q.imask) == 2'h0 |-> !irq)
    else $error("interrupt raised without a done event");
  a_write_sends: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    en && wr_go && q.awa == uct_pkg::OFF_TXD && q.wen && pwr
    && q.ctrl[uct_pkg::CTRL_TXE] && q.tx_st == uct_pkg::TX_IDLE
    ##1 en |-> q.tx_st == uct_pkg::TX_SHIFT && !serial_transmit_output)
    else $error("data write did not start a frame");

  a_div_range: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    q.kdiv >= uct_pkg::DIV_MIN)
    else $error("divisor below minimum");
  a_rx_latch: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rx_go ##1 en [*2] |-> !r_mid)
    else $error("receive latch too early after start");

  a_idle_mark: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    q.tx_st == uct_pkg::TX_IDLE |-> serial_transmit_output)
    else $error("transmit line not high while idle");
endmodule : uct_uart
`default_nettype wire
